// >>> core/timer_pulse_unit.sv
// Six-channel 16-bit timer pulse unit with register port.
`timescale 1ns/1ps
`include "tpu_regs.svh"
module timer_pulse_unit
    import tpu_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // External clock inputs a..d
    input wire logic [3:0] ext_clock_in,
    // Timer I/O pins, channel*4 + register
    input wire logic [23:0] timer_io_pin_in,
    output logic [23:0] timer_io_pin_out,
    output logic [23:0] timer_io_pin_oe,
    // Requests to interrupt and transfer controllers
    output logic [25:0] irq_req,
    output logic irq_any,
    output logic [4:0] irq_top,
    output logic [15:0] xfer_req
);

    function automatic logic presc_tick(input logic [3:0] sel,
                                        input logic [11:0] p);
        logic [11:0] m;
        m = 12'h000;
        for (int k = 0; k < `PRESC_STEPS; k++) begin
            if (sel > 4'(k)) begin
                m[2*k +: 2] = 2'h3;
            end
        end
        return &(p | ~m);
    endfunction

    function automatic logic chan_hit(input logic [7:0] a,
                                      input logic [3:0] ch,
                                      input logic [3:0] off);
        return (a[7:4] == ch) && (a[3:0] == off);
    endfunction

    function automatic logic pin_result(input logic [1:0] act,
                                        input logic cur);
        case (act)
            2'h1: pin_result = 1'b0;
            2'h2: pin_result = 1'b1;
            2'h3: pin_result = ~cur;
            default: pin_result = cur;
        endcase
    endfunction

    function automatic logic [4:0] first_set(input logic [25:0] v);
        logic [4:0] i;
        i = 5'h1f;
        for (int k = 25; k >= 0; k--) begin
            if (v[k]) begin
                i = 5'(k);
            end
        end
        return i;
    endfunction

    // Two-stage synchronisers, third stage only for edge detection
    logic [27:0] sync1_reg, sync2_reg, sync3_reg;
    logic [27:0] rise, fall;
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            sync1_reg <= 28'h0000000;
            sync2_reg <= 28'h0000000;
            sync3_reg <= 28'h0000000;
        end else begin
            sync1_reg <= {ext_clock_in, timer_io_pin_in};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end
    assign rise = sync2_reg & ~sync3_reg;
    assign fall = ~sync2_reg & sync3_reg;

    logic [`PRESC_W-1:0] presc_reg;
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            presc_reg <= 12'h000;
        end else begin
            presc_reg <= presc_reg + 12'h001;
        end
    end

    // Global start and synchronous-operation registers
    logic [5:0] start_reg, sync_reg;
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            start_reg <= `RST_CH;
            sync_reg <= `RST_CH;
        end else begin
            if (reg_wr && chan_hit(reg_addr, `CH_GLOBAL, `OFF_START)) begin
                start_reg <= reg_wdata[5:0];
            end
            if (reg_wr && chan_hit(reg_addr, `CH_GLOBAL, `OFF_SYNC)) begin
                sync_reg <= reg_wdata[5:0];
            end
        end
    end

    logic [5:0] ovf_v, unf_v, clr_own_v, cnt_wr_v;
    logic [35:0] req_v;
    logic [95:0] rd_v;
    logic sync_wr, sync_clr;
    // one preset reaches every synchronized counter
    assign sync_wr = |(cnt_wr_v & sync_reg);
    // one clear reaches every synchronized counter
    assign sync_clr = |(clr_own_v & sync_reg);

    for (genvar c = 0; c < 6; c++) begin : ch
        localparam bit HAS4 = (c == 0) || (c == 3);
        localparam int NR = HAS4 ? 4 : 2;
        localparam int PA = (c == 1 || c == 5) ? 24 : 26;
        localparam bit UPPER = (c == 1) || (c == 4);
        localparam int LO = UPPER ? c + 1 : c;
        logic [15:0] ctrl_reg, mode_reg, io_reg, cnt_reg, rd_val;
        logic [5:0] ier_reg, sr_reg, set_ev;
        logic [15:0] gr_reg [0:3];
        logic [3:0] pin_reg, match, cap, ev, oe;
        logic wsel, phase, tick_clk, ph_up, ph_dn, aup, adn, bup, bdn;
        logic up, dn, load, clr;
        mode_e md;
        clk_sel_e cks;
        clr_sel_e ccl;

        assign md = mode_e'(mode_reg[`MODE_MD_LSB +: 3]);
        assign cks = clk_sel_e'(ctrl_reg[`CTRL_CKS_LSB +: 4]);
        assign ccl = clr_sel_e'(ctrl_reg[`CTRL_CCLR_LSB +: 3]);
        assign wsel = reg_wr && (reg_addr[7:4] == 4'(c));

        always_ff @(posedge core_clk) begin
            if (!reset_n) begin
                ctrl_reg <= `RST_WORD;
                mode_reg <= `RST_WORD;
                io_reg <= `RST_WORD;
                ier_reg <= `RST_FLAGS;
            end else if (wsel) begin
                case (reg_addr[3:0])
                    `OFF_CTRL: ctrl_reg <= reg_wdata;
                    `OFF_MODE: mode_reg <= reg_wdata;
                    `OFF_IOCTL: io_reg <= reg_wdata;
                    `OFF_IER: ier_reg <= reg_wdata[5:0];
                    default: ;
                endcase
            end
        end

        // phase counting only where the channel allows it
        assign phase = !HAS4 && (md == MODE_PHASE1 || md == MODE_PHASE2 ||
                                 md == MODE_PHASE3 || md == MODE_PHASE4);
        // phase pair is a/b or c/d by channel
        // edge on one phase, level of the other sets direction
        assign aup = (rise[PA] & ~sync2_reg[PA+1]) |
                     (fall[PA] & sync2_reg[PA+1]);
        assign adn = (rise[PA] & sync2_reg[PA+1]) |
                     (fall[PA] & ~sync2_reg[PA+1]);
        assign bup = (sync2_reg[PA] & rise[PA+1]) |
                     (~sync2_reg[PA] & fall[PA+1]);
        assign bdn = (sync2_reg[PA] & fall[PA+1]) |
                     (~sync2_reg[PA] & rise[PA+1]);
        always_comb begin
            case (md)
                MODE_PHASE1: begin
                    ph_up = aup | bup;
                    ph_dn = adn | bdn;
                end
                MODE_PHASE2: begin
                    ph_up = aup;
                    ph_dn = adn;
                end
                MODE_PHASE3: begin
                    ph_up = bup;
                    ph_dn = bdn;
                end
                default: begin
                    ph_up = rise[PA] & ~sync2_reg[PA+1];
                    ph_dn = rise[PA] & sync2_reg[PA+1];
                end
            endcase
        end

        // internal division or an external clock edge
        always_comb begin
            case (cks)
                CK_EXT_A: tick_clk = rise[24];
                CK_EXT_B: tick_clk = rise[25];
                CK_EXT_C: tick_clk = rise[26];
                CK_EXT_D: tick_clk = rise[27];
                CK_CASCADE: tick_clk = 1'b0;
                default: tick_clk = presc_tick(cks, presc_reg);
            endcase
        end

        // up and down counting; upper half follows lower carries and borrows
        assign up = start_reg[c] && (phase ? ph_up : (tick_clk ||
                    (UPPER && cks == CK_CASCADE && ovf_v[LO])));
        assign dn = start_reg[c] && (phase ? ph_dn :
                    (UPPER && cks == CK_CASCADE && unf_v[LO]));

        // per-register compare or capture, edges chosen per register
        always_comb begin
            for (int r = 0; r < 4; r++) begin
                match[r] = (r < NR) && !io_reg[r*4+3] && (up || dn) &&
                           (cnt_reg == gr_reg[r]);
                // selected pin edge captures the counter
                cap[r] = (r < NR) && io_reg[r*4+3] &&
                         ((io_reg[r*4] && rise[c*4+r]) ||
                          (io_reg[r*4+1] && fall[c*4+r]));
                ev[r] = match[r] || cap[r];
            end
        end

        // clear on the chosen register's match or capture
        always_comb begin
            case (ccl)
                CLR_A: clr_own_v[c] = ev[0];
                CLR_B: clr_own_v[c] = ev[1];
                CLR_C: clr_own_v[c] = ev[2];
                CLR_D: clr_own_v[c] = ev[3];
                default: clr_own_v[c] = 1'b0;
            endcase
        end
        assign cnt_wr_v[c] = wsel && reg_addr[3:0] == `OFF_CNT;
        assign load = cnt_wr_v[c] || (sync_reg[c] && sync_wr);
        assign clr = clr_own_v[c] || (sync_reg[c] && sync_clr);
        assign ovf_v[c] = up && !load && !clr && cnt_reg == 16'hffff;
        assign unf_v[c] = dn && !up && !load && !clr && cnt_reg == 16'h0000;

        // preset and clear act in the same cycle on all members
        always_ff @(posedge core_clk) begin
            if (!reset_n) begin
                cnt_reg <= `RST_WORD;
            end else if (load) begin
                cnt_reg <= reg_wdata;
            end else if (clr) begin
                cnt_reg <= `RST_WORD;
            end else if (up) begin
                cnt_reg <= cnt_reg + 16'h0001;
            end else if (dn) begin
                cnt_reg <= cnt_reg - 16'h0001;
            end
        end

        // Hardware capture beats a software write in the same cycle
        always_ff @(posedge core_clk) begin
            if (!reset_n) begin
                for (int r = 0; r < 4; r++) begin
                    gr_reg[r] <= `RST_WORD;
                end
            end else begin
                for (int r = 0; r < NR; r++) begin
                    if (wsel && reg_addr[3:0] == 4'(`OFF_GRA + r)) begin
                        gr_reg[r] <= reg_wdata;
                    end
                end
                for (int r = 0; r < 2; r++) begin
                    // A and B each capture this channel's own counter
                    if (cap[r]) begin
                        gr_reg[r] <= cnt_reg;
                    end
                    // buffers exist only on four-register channels
                    if (HAS4 && mode_reg[`MODE_BUFA_BIT + r]) begin
                        // capture pushes previous value to buffer
                        if (cap[r]) begin
                            gr_reg[r+2] <= gr_reg[r];
                        end
                        // match reloads from buffer with the pin change
                        if (match[r]) begin
                            gr_reg[r] <= gr_reg[r+2];
                        end
                    end
                end
                for (int r = 2; r < NR; r++) begin
                    if (cap[r]) begin
                        gr_reg[r] <= cnt_reg;
                    end
                end
            end
        end

        // match result per register; in PWM 1 pairs drive the even pin
        always_ff @(posedge core_clk) begin
            if (!reset_n) begin
                pin_reg <= 4'h0;
            end else begin
                for (int r = 0; r < NR; r++) begin
                    if (md == MODE_PWM1) begin
                        if (r % 2 == 0 && match[r]) begin
                            pin_reg[r] <= pin_result(io_reg[r*4 +: 2],
                                                     pin_reg[r]);
                        end else if (r % 2 == 0 && match[r|1]) begin
                            pin_reg[r] <= pin_result(io_reg[(r|1)*4 +: 2],
                                                     pin_reg[r]);
                        end
                    end else if (match[r]) begin
                        pin_reg[r] <= pin_result(io_reg[r*4 +: 2],
                                                 pin_reg[r]);
                    end
                end
            end
        end
        // in PWM 2 a compare pin drives when its action is nonzero; the cycle one clears
        always_comb begin
            for (int r = 0; r < 4; r++) begin
                if (r >= NR || io_reg[r*4+3]) begin
                    oe[r] = 1'b0;
                end else if (md == MODE_PWM1) begin
                    oe[r] = (r % 2 == 0) && (io_reg[r*4 +: 2] != 2'h0 ||
                            io_reg[(r|1)*4 +: 2] != 2'h0);
                end else begin
                    oe[r] = io_reg[r*4 +: 2] != 2'h0;
                end
            end
        end
        assign timer_io_pin_out[c*4 +: 4] = pin_reg;
        assign timer_io_pin_oe[c*4 +: 4] = oe;

        // sticky flags; a new event wins over a write of zero
        assign set_ev = {unf_v[c], ovf_v[c], ev};
        always_ff @(posedge core_clk) begin
            if (!reset_n) begin
                sr_reg <= `RST_FLAGS;
            end else if (wsel && reg_addr[3:0] == `OFF_SR) begin
                sr_reg <= (sr_reg & reg_wdata[5:0]) | set_ev;
            end else begin
                sr_reg <= sr_reg | set_ev;
            end
        end
        assign req_v[c*6 +: 6] = sr_reg & ier_reg;

        always_comb begin
            case (reg_addr[3:0])
                `OFF_CTRL: rd_val = ctrl_reg;
                `OFF_MODE: rd_val = mode_reg;
                `OFF_IOCTL: rd_val = io_reg;
                `OFF_IER: rd_val = {10'h000, ier_reg};
                `OFF_SR: rd_val = {10'h000, sr_reg};
                `OFF_CNT: rd_val = cnt_reg;
                4'h6: rd_val = gr_reg[0];
                4'h7: rd_val = gr_reg[1];
                4'h8: rd_val = gr_reg[2];
                4'h9: rd_val = gr_reg[3];
                default: rd_val = 16'h0000;
            endcase
        end
        assign rd_v[c*16 +: 16] = rd_val;
    end

    // twenty-six sources; bit 0 is the highest priority
    assign irq_req = {req_v[35:34], req_v[31:30], req_v[29:28],
                      req_v[25:24], req_v[22:18], req_v[17:16],
                      req_v[13:12], req_v[11:10], req_v[7:6], req_v[4:0]};
    // overflow and underflow never start a transfer
    assign xfer_req = {req_v[31:30], req_v[25:24], req_v[21:18],
                      req_v[13:12], req_v[7:6], req_v[3:0]};
    assign irq_any = |irq_req;

    // registered index of the most urgent pending source
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            irq_top <= 5'h1f;
        end else begin
            irq_top <= first_set(irq_req);
        end
    end

    // Read data only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            reg_rdata <= `RST_WORD;
        end else if (!reg_rd) begin
            reg_rdata <= `RST_WORD;
        end else if (reg_addr[7:4] == `CH_GLOBAL) begin
            reg_rdata <= (reg_addr[3:0] == `OFF_START) ? {10'h000, start_reg}
                       : (reg_addr[3:0] == `OFF_SYNC) ? {10'h000, sync_reg}
                       : `RST_WORD;
        end else if (reg_addr[7:4] < 4'h6) begin
            reg_rdata <= rd_v[reg_addr[6:4]*16 +: 16];
        end else begin
            reg_rdata <= `RST_WORD;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    ovf_flag_a: assert property (
        ovf_v[0] |=> ch[0].sr_reg[`SR_OVF_BIT])
        else $error("overflow did not set its flag");
    xfer_ovf_a: assert property (
        ovf_v[3] && !(|ch[3].ev) && xfer_req[11:8] == 4'h0 |=>
        xfer_req[11:8] == 4'h0 && irq_req[17] == ch[3].ier_reg[4])
        else $error("overflow reached the transfer request");
    pri_top_a: assert property (
        irq_req[0] |=> irq_top == 5'h00)
        else $error("channel 0 A was not the top request");
    cnt_clear_a: assert property (
        clr_own_v[0] && !ch[0].load |=> ch[0].cnt_reg == 16'h0000)
        else $error("counter not cleared by its source");
    capture_a: assert property (
        ch[0].cap[0] |=> ch[0].gr_reg[0] == $past(ch[0].cnt_reg))
        else $error("capture did not store the counter");
    buf_cap_a: assert property (
        ch[0].cap[0] && ch[0].mode_reg[`MODE_BUFA_BIT]
        |=> ch[0].gr_reg[2] == $past(ch[0].gr_reg[0]))
        else $error("capture did not shift into buffer");
    buf_cmp_a: assert property (
        ch[3].match[1] && ch[3].mode_reg[`MODE_BUFB_BIT] && !ch[3].cap[1]
        |=> ch[3].gr_reg[1] == $past(ch[3].gr_reg[3]))
        else $error("compare did not reload from buffer");
    pin_toggle_a: assert property (
        ch[0].match[0] && ch[0].io_reg[3:0] == 4'h3 &&
        ch[0].md == MODE_NORMAL
        |=> timer_io_pin_out[0] != $past(timer_io_pin_out[0]))
        else $error("toggle output did not change");
    sync_load_a: assert property (
        sync_wr && sync_reg[2] |=> ch[2].cnt_reg == $past(reg_wdata))
        else $error("synchronized preset missed a channel");
    sync_clear_a: assert property (
        sync_clr && sync_reg[5] && !sync_wr |=> ch[5].cnt_reg == 16'h0000)
        else $error("synchronized clear missed a channel");
    cascade_a: assert property (
        ovf_v[2] && ch[1].cks == CK_CASCADE && !ch[1].phase &&
        !ch[1].load && !ch[1].clr && start_reg[1]
        |=> ch[1].cnt_reg == $past(ch[1].cnt_reg) + 16'h0001)
        else $error("upper counter missed the carry");

    pwm_cover_c: cover property (ch[0].md == MODE_PWM1 && ch[0].match[1]);
    phase_cover_c: cover property (ch[1].phase && unf_v[1]);
    sync_cover_c: cover property (sync_clr && sync_reg[1] && sync_reg[0]);
endmodule

// >>> core/tpu_pkg.sv
// Types shared by the timer pulse unit.
package tpu_pkg;
    typedef logic [15:0] word_t;
    // Counting modes, Gray coded
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h0,
        MODE_PWM1 = 3'h1,
        MODE_PWM2 = 3'h3,
        MODE_PHASE1 = 3'h2,
        MODE_PHASE2 = 3'h6,
        MODE_PHASE3 = 3'h7,
        MODE_PHASE4 = 3'h5
    } mode_e;
    typedef enum logic [3:0] {
        CK_DIV1 = 4'h0, CK_DIV4 = 4'h1, CK_DIV16 = 4'h2, CK_DIV64 = 4'h3,
        CK_DIV256 = 4'h4, CK_DIV1024 = 4'h5, CK_DIV4096 = 4'h6,
        CK_EXT_A = 4'h7, CK_EXT_B = 4'h8, CK_EXT_C = 4'h9, CK_EXT_D = 4'ha,
        CK_CASCADE = 4'hb
    } clk_sel_e;
    typedef enum logic [2:0] {
        CLR_NONE = 3'h0, CLR_A = 3'h1, CLR_B = 3'h2, CLR_C = 3'h3,
        CLR_D = 3'h4, CLR_SYNC = 3'h5
    } clr_sel_e;
endpackage

// >>> core/tpu_regs.svh
// Register offsets, field positions, reset values and timing counts.
// How it works
// - Per-channel compare, overflow interrupt flags; underflow on 1,2,4,5
// - Only compare/capture flags request data transfers
// - Fixed request order, channel 0 A first
// - Up counter: free-run, cyclic clear, events
// - Each general register: compare or capture
// - Buffering only on channels 0 and 3
// - Compare match copies buffer into register
// - Capture shifts old register into buffer
// - Match drives pin low, high or toggled
// - Clear source is one register's event
// - PWM 1 pairs A with B, C with D
// - PWM 2: one cycle register, rest duty
// - Pin edge captures counter, selectable edges
// - Four phase counting modes, channels 1,2,4,5
// - Phase inputs: A/B for 1,5; C/D for 2,4
// - Channel 1 and 4 count lower carries
// - Counter write presets all synchronized channels
// - A synchronized channel's clear clears all synchronized channels
// - Clock: divide 1..4096 or four externals
`ifndef TPU_REGS_SVH
`define TPU_REGS_SVH

// Word offsets inside a channel block (address bits 3:0)
`define OFF_CTRL 4'h0
`define OFF_MODE 4'h1
`define OFF_IOCTL 4'h2
`define OFF_IER 4'h3
`define OFF_SR 4'h4
`define OFF_CNT 4'h5
`define OFF_GRA 4'h6
// Global block sits at channel slot 6
`define CH_GLOBAL 4'h6
`define OFF_START 4'h0
`define OFF_SYNC 4'h1

// Field positions
`define CTRL_CKS_LSB 0
`define CTRL_CCLR_LSB 4
`define MODE_MD_LSB 0
`define MODE_BUFA_BIT 4
`define MODE_BUFB_BIT 5
`define SR_OVF_BIT 4
`define SR_UNF_BIT 5

// Reset values
`define RST_WORD 16'h0000
`define RST_FLAGS 6'h00
`define RST_CH 6'h00

// Prescaler: longest division is 2**12
`define PRESC_W 12
`define PRESC_STEPS 6

`endif

// >>> tb/six_channel_timer_pulse_unit_bench.sv
// Register-level bench of the six-channel timer pulse unit.
`timescale 1ns/1ps
module six_channel_timer_pulse_unit_bench;
    import tpu_pkg::*;
    logic core_clk, reset_n, reg_wr, reg_rd, irq_any;
    logic [7:0] reg_addr;
    word_t reg_wdata, reg_rdata, rd_val;
    logic [23:0] pin_in, pin_out, pin_oe;
    logic [3:0] ext_in;
    logic [25:0] irq_req;
    logic [4:0] irq_top;
    logic [15:0] xfer_req;
    int n_mismatch, checks, gap;

    timer_pulse_unit dut (.core_clk(core_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clock_in(ext_in),
        .timer_io_pin_in(pin_in), .timer_io_pin_out(pin_out),
        .timer_io_pin_oe(pin_oe), .irq_req(irq_req), .irq_any(irq_any),
        .irq_top(irq_top), .xfer_req(xfer_req));
    timer_io_partner pins (.core_clk(core_clk), .pin_level(pin_in),
        .ext_level(ext_in));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic wr(input logic [7:0] a, input word_t d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask
    task automatic chk(input word_t got, input word_t exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input word_t exp);
        rd(a);
        chk(rd_val, exp);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Counts settled cycles until the pin reaches the level
    task automatic wait_pin(input int i, input logic v);
        gap = 0;
        while (pin_out[i] !== v && gap < 50) begin
            @(posedge core_clk);
            #1 gap++;
        end
        if (pin_out[i] !== v) begin
            n_mismatch++;
            complete_run;
        end
    endtask

    initial begin
        reset_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        n_mismatch = 0;
        checks = 0;
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        rd_chk(8'h00, 16'h0000);
        chk({11'h000, irq_top}, 16'h001f);
        $display("reset test done");
        // Toggle on A, clear on A, so three ticks between edges
        wr(8'h02, 16'h0003);
        wr(8'h06, 16'h0002);
        wr(8'h00, 16'h0010);
        wr(8'h03, 16'h0001);
        wr(8'h60, 16'h0001);
        wait_pin(0, 1'b1);
        wait_pin(0, 1'b0);
        chk(16'(gap), 16'h0003);
        chk({15'h0000, irq_req[0]}, 16'h0001);
        chk(xfer_req, 16'h0001);
        chk({15'h0000, irq_any}, 16'h0001);
        chk({11'h000, irq_top}, 16'h0000);
        chk({15'h0000, pin_oe[0]}, 16'h0001);
        // Registers B to D compare against zero and match too
        rd_chk(8'h04, 16'h000f);
        wr(8'h60, 16'h0000);
        wr(8'h04, 16'h0000);
        rd_chk(8'h04, 16'h0000);
        chk({11'h000, irq_top}, 16'h001f);
        chk({15'h0000, irq_any}, 16'h0000);
        $display("compare test done");
        // Buffered capture on both edges with the counter stopped
        wr(8'h02, 16'h000b);
        wr(8'h01, 16'h0010);
        wr(8'h05, 16'h1111);
        pins.set_pin(0, 1'b1);
        wr(8'h05, 16'h2222);
        pins.set_pin(0, 1'b0);
        rd_chk(8'h06, 16'h2222);
        rd_chk(8'h08, 16'h1111);
        chk({15'h0000, pin_oe[0]}, 16'h0000);
        $display("capture test done");
        // Channels 0 and 1 synchronised: preset, then clear by capture
        wr(8'h61, 16'h0003);
        wr(8'h05, 16'h00ab);
        rd_chk(8'h15, 16'h00ab);
        pins.set_pin(0, 1'b1);
        rd_chk(8'h15, 16'h0000);
        rd_chk(8'h06, 16'h00ab);
        wr(8'h61, 16'h0000);
        $display("sync test done");
        // PWM 1 on channel 2: A period 4 drives low, B duty 1 high
        wr(8'h22, 16'h0021);
        wr(8'h26, 16'h0004);
        wr(8'h27, 16'h0001);
        wr(8'h20, 16'h0010);
        wr(8'h21, 16'h0001);
        wr(8'h60, 16'h0004);
        wait_pin(8, 1'b1);
        wait_pin(8, 1'b0);
        chk(16'(gap), 16'h0003);
        wait_pin(8, 1'b1);
        chk(16'(gap), 16'h0002);
        chk({14'h0000, pin_oe[9:8]}, 16'h0001);
        $display("pwm test done");
        // Phase counting on channel 1 from external clocks a and b
        wr(8'h11, 16'h0002);
        wr(8'h60, 16'h0002);
        repeat (4) pins.quad_step(1'b1, 0);
        rd_chk(8'h15, 16'h0004);
        repeat (6) pins.quad_step(1'b0, 0);
        rd_chk(8'h15, 16'hfffe);
        // Zero crossings also match A and B, both at zero
        rd_chk(8'h14, 16'h0023);
        // Mode 4 counts only rising a: one per full cycle
        wr(8'h11, 16'h0005);
        repeat (4) pins.quad_step(1'b1, 0);
        rd_chk(8'h15, 16'hffff);
        $display("phase test done");
        complete_run;
    end
endmodule

// >>> tb/timer_io_partner.sv
// Far-side model: timer pin levels and a quadrature encoder.
`timescale 1ns/1ps
module timer_io_partner (
    // Clock
    input wire logic core_clk,
    // Levels toward the timer
    output logic [23:0] pin_level,
    output logic [3:0] ext_level
);
    logic [1:0] phase_reg;
    initial begin
        pin_level = 24'h000000;
        ext_level = 4'h0;
        phase_reg = 2'h0;
    end
    // Held long enough to clear the two-stage synchroniser
    task automatic set_pin(input int i, input logic v);
        @(posedge core_clk);
        pin_level[i] <= v;
        repeat (5) @(posedge core_clk);
    endtask
    // gray phases, a leads b going up
    task automatic quad_step(input logic up, input int lane);
        phase_reg = up ? phase_reg + 2'h1 : phase_reg - 2'h1;
        @(posedge core_clk);
        ext_level[lane*2 +: 2] <= {phase_reg[1], ^phase_reg};
        repeat (5) @(posedge core_clk);
    endtask
endmodule
